// *** logic/eprom_host.sv ***
// Host-side read controller for an asynchronous 32K x 8 read-only memory
//
// Summary of operation
// - Full address driven in parallel on dedicated lines; no latch strobe.
// - Host uses select for choice and power, gate to put data on bus.
// - Data valid 60 ns after gate falls, if select/address set up 60 ns before.
// - Gate may lag select by select access minus gate access time.
`timescale 1ns/10ps
`include "eprom_host_map.svh"

module eprom_host
	import eprom_host_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Read request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic hold_select,
	// Read answer
	output logic resp_valid,
	output logic [`DATA_W-1:0] resp_data,
	output logic busy,
	// Memory pins
	output logic [`ADDR_W-1:0] word_address_lines,
	output logic select_n,
	output logic gate_n,
	input wire logic [`DATA_W-1:0] read_data_lines
);

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int SETUP_N = `SETUP_CYC;
	localparam int ACCESS_N = `GATE_CYC + `SYNC_STAGES;
	localparam int ADDR_N = `ADDR_CYC + `SYNC_STAGES;
	localparam int RELEASE_N = `RELEASE_CYC;

	// Counter load value for a stay of n cycles
	function automatic logic [`CNT_W-1:0] stay(input int n);
		return `CNT_W'(n - 1);
	endfunction

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_n;
	logic [`DATA_W-1:0] data_sync;

	sync_stage #(
		.WIDTH(1),
		.CLEAR_VALUE(1'b0)
	) u_reset_sync (
		.mclk(mclk),
		.clear_n(resetn),
		.d(1'b1),
		.q(rst_n)
	);

	sync_stage #(
		.WIDTH(`DATA_W),
		.CLEAR_VALUE('0)
	) u_data_sync (
		.mclk(mclk),
		.clear_n(rst_n),
		.d(read_data_lines),
		.q(data_sync)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	host_regs_t r;
	host_regs_t next_r;
	logic take;

	// Requests are taken only with the bus idle or held selected
	assign req_ready = (r.state == ST_IDLE) || (r.state == ST_HELD);
	assign take = req_valid && req_ready;

	always_comb begin
		next_r = r;
		next_r.resp_valid = 1'b0;
		if (r.count != '0) begin
			next_r.count = r.count - `CNT_W'(1);
		end
		unique case (r.state)
			ST_IDLE: begin
				// Standby: select high keeps the device powered down
				next_r.select_n = 1'b1;
				next_r.gate_n = 1'b1;
				if (take) begin
					// Whole address and select go out together
					next_r.addr = req_addr;
					next_r.select_n = 1'b0;
					next_r.count = stay(SETUP_N);
					next_r.state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address and select settle before the gate falls
				if (r.count == '0) begin
					next_r.gate_n = 1'b0;
					next_r.count = stay(ACCESS_N);
					next_r.state = ST_ACCESS;
				end
			end
			ST_ACCESS, ST_ADDR_WAIT: begin
				// Sample only while both controls are low
				if (r.count == '0) begin
					next_r.resp_data = data_sync;
					next_r.resp_valid = 1'b1;
					if (hold_select) begin
						next_r.state = ST_HELD;
					end else begin
						next_r.select_n = 1'b1;
						next_r.gate_n = 1'b1;
						next_r.count = stay(RELEASE_N);
						next_r.state = ST_RELEASE;
					end
				end
			end
			ST_HELD: begin
				// Device stays selected and driving; a new address restarts access
				if (take) begin
					next_r.addr = req_addr;
					next_r.count = stay(ADDR_N);
					next_r.state = ST_ADDR_WAIT;
				end else if (!hold_select) begin
					next_r.select_n = 1'b1;
					next_r.gate_n = 1'b1;
					next_r.count = stay(RELEASE_N);
					next_r.state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				// Give the device time to float its outputs before the next select
				if (r.count == '0) begin
					next_r.state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{
				state: ST_IDLE,
				count: '0,
				addr: '0,
				select_n: 1'b1,
				gate_n: 1'b1,
				resp_valid: 1'b0,
				resp_data: '0
			};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign word_address_lines = r.addr;
	assign select_n = r.select_n;
	assign gate_n = r.gate_n;
	assign resp_valid = r.resp_valid;
	assign resp_data = r.resp_data;
	assign busy = (r.state != ST_IDLE);

endmodule

// *** logic/eprom_host_map.svh ***
// Timing figures, cycle counts and widths for the parallel memory read controller
`ifndef EPROM_HOST_MAP_SVH
`define EPROM_HOST_MAP_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define WORD_COUNT 32768
`define ADDR_W 15
`define DATA_W 8

// ----------------------------------------------------------------
// Clock and pin timing, in ns
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 100
`define ADDRESS_ACCESS_DELAY_NS 120
`define SELECT_ACCESS_DELAY_NS 120
`define GATE_ACCESS_DELAY_NS 60
`define OUTPUT_RELEASE_DELAY_NS 30

// ----------------------------------------------------------------
// Derived cycle counts (least times round up, never below one)
// ----------------------------------------------------------------
`define CEIL_CYC(ns) (((ns) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define AT_LEAST_ONE(c) (((c) < 1) ? 1 : (c))
`define SETUP_CYC `AT_LEAST_ONE(`CEIL_CYC(`ADDRESS_ACCESS_DELAY_NS - `GATE_ACCESS_DELAY_NS))
`define GATE_CYC_RAW `AT_LEAST_ONE(`CEIL_CYC(`GATE_ACCESS_DELAY_NS))
`define GATE_CYC_CE `AT_LEAST_ONE(`CEIL_CYC(`SELECT_ACCESS_DELAY_NS) - `SETUP_CYC)
`define GATE_CYC ((`GATE_CYC_RAW > `GATE_CYC_CE) ? `GATE_CYC_RAW : `GATE_CYC_CE)
`define ADDR_CYC `AT_LEAST_ONE(`CEIL_CYC(`ADDRESS_ACCESS_DELAY_NS))
`define RELEASE_CYC `AT_LEAST_ONE(`CEIL_CYC(`OUTPUT_RELEASE_DELAY_NS))
`define SYNC_STAGES 2
`define CNT_W 4

`endif

// *** logic/eprom_host_pkg.sv ***
// Types shared by the parallel memory read controller
`include "eprom_host_map.svh"

package eprom_host_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACCESS,
		ST_HELD,
		ST_ADDR_WAIT,
		ST_RELEASE
	} host_state_t;

	typedef struct packed {
		host_state_t state;
		logic [`CNT_W-1:0] count;
		logic [`ADDR_W-1:0] addr;
		logic select_n;
		logic gate_n;
		logic resp_valid;
		logic [`DATA_W-1:0] resp_data;
	} host_regs_t;

endpackage

// *** logic/sync_stage.sv ***
// Two-flop synchroniser with asynchronous clear to a fixed value
`timescale 1ns/10ps

module sync_stage #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] CLEAR_VALUE = '0
) (
	// Clock and clear
	input wire logic mclk,
	input wire logic clear_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_regs_t;

	sync_regs_t r;
	sync_regs_t next_r;

	always_comb begin
		next_r.first = d;
		next_r.second = r.first;
	end

	always_ff @(posedge mclk or negedge clear_n) begin
		if (!clear_n) begin
			r <= {CLEAR_VALUE, CLEAR_VALUE};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.second;

endmodule

// *** sim/eprom_model.sv ***
// Behavioural read-only memory on the controller's pins
`timescale 1ns/10ps
`include "eprom_host_map.svh"
module eprom_model #(
	parameter int ACCESS_NS = `GATE_ACCESS_DELAY_NS
) (
	// Host pins
	input wire logic [`ADDR_W-1:0] word_address_lines,
	input wire logic select_n,
	input wire logic gate_n,
	output logic [`DATA_W-1:0] read_data_lines
);
	logic [`DATA_W-1:0] word = '0;
	assign read_data_lines = word;
	// Released lines invert on every pin change, so the last word returns once select falls with gate high
	always @(word_address_lines, select_n, gate_n) begin
		if (!select_n && !gate_n) begin
			word <= #(ACCESS_NS) word_address_lines[7:0] + {1'b0, word_address_lines[14:8]};
		end else begin
			word <= #(`OUTPUT_RELEASE_DELAY_NS) ~word;
		end
	end
endmodule

// *** sim/eprom_host_chk.sv ***
// Checker bound to the memory read controller
`timescale 1ns/10ps
`include "eprom_host_map.svh"
module eprom_host_chk (
	// Clock, reset, request and answer
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic resp_valid,
	input wire logic [`DATA_W-1:0] resp_data,
	// Memory pins
	input wire logic [`ADDR_W-1:0] word_address_lines,
	input wire logic select_n,
	input wire logic gate_n,
	input wire logic [`DATA_W-1:0] read_data_lines
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	take_addr_a: assert property (req_valid && req_ready |=> !select_n && word_address_lines == $past(req_addr))
		else $error("select or address missing after take");
	access_setup_a: assert property (resp_valid |-> !$past(select_n, 4) && !$past(gate_n, 3))
		else $error("word taken before access time");
	addr_steady_a: assert property (resp_valid |-> word_address_lines == $past(word_address_lines, 4))
		else $error("address moved during access");
	capture_a: assert property (resp_valid |-> resp_data == $past(read_data_lines, 3))
		else $error("answer differs from pins");
	gate_select_a: assert property (!gate_n |-> !select_n)
		else $error("gate low while deselected");
	gate_lag_a: assert property ($fell(gate_n) |-> !$past(select_n))
		else $error("gate fell before select");
	release_gap_a: assert property ($rose(select_n) |=> select_n)
		else $error("no release gap");
	answer_time_a: assert property (req_valid && req_ready |=> !resp_valid [*4] ##1 resp_valid)
		else $error("answer not on fifth edge");
	held_c: cover property (resp_valid && !select_n);
	idle_c: cover property (resp_valid && select_n);
	lag_c: cover property ($fell(gate_n));
endmodule
bind eprom_host eprom_host_chk u_eprom_host_chk (.mclk(mclk), .resetn(resetn), .req_valid(req_valid),
	.req_ready(req_ready), .req_addr(req_addr), .resp_valid(resp_valid), .resp_data(resp_data),
	.word_address_lines(word_address_lines), .select_n(select_n), .gate_n(gate_n), .read_data_lines(read_data_lines));

// *** sim/uv_eprom_async_read_port_tb_top.sv ***
// Self-checking bench for the memory read controller
`timescale 1ns/10ps
`include "eprom_host_map.svh"
module uv_eprom_async_read_port_tb_top;
	logic mclk = 0;
	logic resetn = 0;
	logic req_valid = 0;
	logic hold_select = 0;
	logic [`ADDR_W-1:0] req_addr = '0;
	logic req_ready, resp_valid, busy, select_n, gate_n;
	logic [`DATA_W-1:0] resp_data, read_data_lines;
	logic [`ADDR_W-1:0] word_address_lines;
	int fail_count = 0;
	int comparisons = 0;
	always #50 mclk = ~mclk;
	eprom_host u_eprom_host (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
		.req_addr(req_addr), .hold_select(hold_select), .resp_valid(resp_valid), .resp_data(resp_data), .busy(busy),
		.word_address_lines(word_address_lines), .select_n(select_n), .gate_n(gate_n), .read_data_lines(read_data_lines));
	eprom_model u_eprom_model (.word_address_lines(word_address_lines), .select_n(select_n), .gate_n(gate_n),
		.read_data_lines(read_data_lines));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task rd(input logic [`ADDR_W-1:0] a, input logic h);
		int n;
		req_addr = a;
		hold_select = h;
		req_valid = 1;
		n = 0;
		while (req_ready !== 1'b1 && n < 20) begin
			@(posedge mclk) #10;
			n++;
		end
		@(posedge mclk) #10;
		req_valid = 0;
		n = 0;
		while (resp_valid !== 1'b1 && n < 20) begin
			@(posedge mclk) #10;
			n++;
		end
		chk(16'(n), 16'h0004);
		chk(resp_data, 8'(a[7:0] + {1'b0, a[14:8]}));
		chk(select_n, !h);
	endtask
	task s_reset;
		chk({busy, select_n, gate_n, resp_valid, req_ready}, 16'h000d);
	endtask
	task s_edges;
		rd('0, 0);
		rd('1, 0);
	endtask
	task s_held;
		rd(15'h1234, 1);
		rd(15'h4321, 1);
		rd(15'h2aaa, 0);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		#10;
		resetn = 1;
		repeat (3) @(posedge mclk);
		#10;
		s_reset();
		s_edges();
		s_held();
		close_out();
	end
	initial begin
		#50000;
		fail_count++;
		close_out();
	end
endmodule
